// ---- rtl/olv_pkg.sv ----
// Purpose: Constants for the open-loop voltage mode controller
// Assumes: 200 MHz clock, 32-bit classic Wishbone register bus
// Notes:   Frequencies in 0.1 Hz steps, voltages in 0.1 V steps
package olv_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADR_MODE  = 8'h00;
	localparam logic [7:0] ADR_RFREQ = 8'h04;
	localparam logic [7:0] ADR_RVOLT = 8'h08;
	localparam logic [7:0] ADR_BOOST = 8'h0c;
	localparam logic [7:0] ADR_RSET  = 8'h10;
	localparam logic [7:0] ADR_OFS   = 8'h14;
	localparam logic [7:0] ADR_STAT  = 8'h18;
	localparam int         STAT_FAIL = 4;
	localparam int         STAT_FRST = 3;
	// ****************************************
	// Voltage mode codes
	// ****************************************
	localparam logic [2:0] MEASURE_EVERY_RUN_MODE               = 3'h0;
	localparam logic [2:0] NO_MEASUREMENT_VECTOR_MODE           = 3'h1;
	localparam logic [2:0] FIXED_LINEAR_MODE                    = 3'h2;
	localparam logic [2:0] MEASURE_ONCE_THEN_LOCK_MODE          = 3'h3;
	localparam logic [2:0] MEASURE_FIRST_RUN_AFTER_POWERUP_MODE = 3'h4;
	localparam logic [2:0] FIXED_SQUARE_MODE                    = 3'h5;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0]  RST_MODE  = 3'h1;
	localparam logic [15:0] RST_RFREQ = 16'h01f4;
	localparam logic [15:0] RST_RVOLT = 16'h0fa0;
	localparam logic [15:0] RST_BOOST = 16'h0000;
	localparam logic [15:0] RST_RSET  = 16'h0000;
	localparam logic [15:0] RST_OFS   = 16'h0000;
	// ****************************************
	// Curve fractions, 4096 = rated frequency
	// ****************************************
	localparam int          FRAC_W   = 12;
	localparam logic [12:0] FRAC_ONE = 13'h1000;
	localparam logic [12:0] FRAC_Q   = 13'h0400;
	localparam logic [12:0] FRAC_H   = 13'h0800;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ       = 200;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYC      = CLK_MHZ * TICK_US;
	localparam int HOLDOFF_S     = 1;
	localparam int HOLDOFF_TICKS = HOLDOFF_S * 1000000 / TICK_US;
	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		S_READY = 4'b0001,
		S_MEAS  = 4'b0010,
		S_RUN   = 4'b0100,
		S_FAULT = 4'b1000
	} olv_state_type;
endpackage

// ---- rtl/olv_curve_if.sv ----
// Purpose: Carries curve settings to the curve generator and results back
// Assumes: Single clock domain
// Notes:   ctl drives settings, crv returns registered voltage
`timescale 1ns/1ps
interface olv_curve_if;
	logic        en;
	logic        vector;
	logic        square;
	logic [15:0] freq;
	logic [15:0] rfreq;
	logic [15:0] rvolt;
	logic [15:0] boost;
	logic [15:0] res;
	logic [15:0] ofs;
	logic [15:0] volt;
	logic [15:0] comp;
	modport ctl (output en, vector, square, freq, rfreq, rvolt, boost,
		res, ofs, input volt, comp);
	modport crv (input en, vector, square, freq, rfreq, rvolt, boost,
		res, ofs, output volt, comp);
endinterface

// ---- rtl/olv_tick.sv ----
// Purpose: Millisecond enable divider and ready-state hold-off timer
// Assumes: clr_i high while the drive is not in the ready state
// Notes:   Timer starts elapsed after reset so the first run may measure
`timescale 1ns/1ps
module olv_tick #(
	parameter int TICK_CYC      = olv_pkg::TICK_CYC,
	parameter int HOLDOFF_TICKS = olv_pkg::HOLDOFF_TICKS
) (
	input  wire logic clk_i,     // System clock
	input  wire logic rst_i,     // Synchronous reset
	input  wire logic clr_i,     // Restart hold-off
	output logic      elapsed_o  // Hold-off time has passed
);
	typedef struct packed {
		logic [31:0] div;
		logic [31:0] cnt;
		logic        tick;
		logic        done;
	} olv_tick_type;
	olv_tick_type r, n;
	always_comb begin
		n = r;
		n.tick = (r.div == 32'(TICK_CYC - 1));
		n.div = n.tick ? 32'h0 : r.div + 32'h1;
		if (clr_i) begin
			n.cnt = 32'h0;
			n.done = 1'b0;
		end else if (r.tick && !r.done) begin
			n.cnt = r.cnt + 32'h1;
			n.done = (n.cnt >= 32'(HOLDOFF_TICKS));
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{div: 32'h0, cnt: 32'h0, tick: 1'b0, done: 1'b1};
		end else begin
			r <= n;
		end
	end
	assign elapsed_o = r.done;
endmodule

// ---- rtl/olv_vcurve.sv ----
// Purpose: Voltage versus frequency curve and resistance weighting
// Assumes: Settings stable while running
// Notes:   Output voltage is zero whenever en is low
`timescale 1ns/1ps
module olv_vcurve (
	input wire logic clk_i,  // System clock
	input wire logic rst_i,  // Synchronous reset
	olv_curve_if.crv cv      // Settings and results
);
	typedef struct packed {
		logic [15:0] volt;
		logic [15:0] comp;
	} olv_crv_type;
	olv_crv_type r, n;
	logic [15:0] fc;
	logic [12:0] frac;
	logic [12:0] w;
	logic [12:0] sq;
	logic [16:0] v;
	function automatic logic [16:0] olv_scale(input logic [15:0] a,
		input logic [12:0] f);
		logic [28:0] p;
		p = 29'(a) * 29'(f);
		return 17'(p >> olv_pkg::FRAC_W);
	endfunction
	always_comb begin
		fc = (cv.freq > cv.rfreq) ? cv.rfreq : cv.freq;
		frac = (cv.rfreq == 16'h0) ? olv_pkg::FRAC_ONE :
			13'(({12'h0, fc, 12'h000}) / {24'h0, cv.rfreq});
		sq = 13'(({13'h0, frac} * {13'h0, frac}) >> olv_pkg::FRAC_W);
		if (frac <= olv_pkg::FRAC_Q)
			w = olv_pkg::FRAC_ONE;
		else if (frac >= olv_pkg::FRAC_H)
			w = 13'h0;
		else
			w = 13'((olv_pkg::FRAC_H - frac) << 2);
		n.comp = 16'h0;
		if (cv.vector) begin
			v = olv_scale(cv.rvolt, frac) + olv_scale(cv.ofs, w);
			n.comp = 16'(olv_scale(cv.res, w));
		end else if (cv.square) begin
			v = olv_scale(cv.rvolt, sq) +
				olv_scale(cv.boost, olv_pkg::FRAC_ONE - frac);
		end else begin
			v = olv_scale(cv.rvolt, frac) +
				olv_scale(cv.boost, olv_pkg::FRAC_ONE - frac);
		end
		n.volt = v[16] ? 16'hffff : v[15:0];
		if (!cv.en) begin
			n.volt = 16'h0;
			n.comp = 16'h0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign cv.volt = r.volt;
	assign cv.comp = r.comp;
	property p_comp_off;
		@(posedge clk_i) disable iff (rst_i)
		(cv.freq >= cv.rfreq && cv.rfreq != 16'h0) |=> (r.comp == 16'h0);
	endproperty
	a_comp_off: assert property (p_comp_off)
		else $error("compensation not zero at rated frequency");
	property p_flat_top;
		@(posedge clk_i) disable iff (rst_i)
		(cv.en && !cv.vector && cv.freq >= cv.rfreq && cv.rfreq != 16'h0)
		|=> (r.volt == cv.rvolt);
	endproperty
	a_flat_top: assert property (p_flat_top)
		else $error("fixed curve not flat above rated frequency");
endmodule

// ---- rtl/olv_top.sv ----
// Purpose: Open-loop voltage mode selection and resistance measurement
// Assumes: run_i is an asynchronous pin; measurement port on clk_i
// Notes:   Registers on classic Wishbone, one word per register
//
// Overview of operation
// - Vector modes give voltage linear in frequency to rated, flat above.
// - Vector modes apply full resistance compensation up to rated/4.
// - Compensation falls linearly from rated/4 to zero at rated/2.
// - Mode 0 measures on every run and overwrites the stored values.
// - Mode 0 skips measurement if run comes within 1 s of entering ready.
// - Mode 4 measures only on the first run after power-up; the code measures on each run until a measurement succeeds.
// - Modes 0 and 4 never write measured values to nonvolatile memory.
// - Mode 1 never measures and uses the stator resistance setting.
// - Mode 3 measures on run and switches to mode 1 after success.
// - Mode 3 success writes resistance, offset and mode to nonvolatile.
// - Mode 3 failure keeps mode 3 and retries on the next run.
// - Fixed-boost modes ignore resistance and offset and use the boost.
// - Mode 2 gives a linear curve to rated frequency, flat above.
// - Mode 5 gives a square-law curve to rated frequency, flat above.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module olv_top #(
	parameter int TICK_CYC      = olv_pkg::TICK_CYC,
	parameter int HOLDOFF_TICKS = olv_pkg::HOLDOFF_TICKS
) (
	input  wire logic        clk_i,       // System clock
	input  wire logic        rst_i,       // Synchronous reset
	input  wire logic [7:0]  wb_adr_i,    // Wishbone byte address
	input  wire logic [31:0] wb_dat_i,    // Wishbone write data
	input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects
	input  wire logic        wb_we_i,     // Wishbone write enable
	input  wire logic        wb_cyc_i,    // Wishbone cycle
	input  wire logic        wb_stb_i,    // Wishbone strobe
	output logic [31:0]      wb_dat_o,    // Wishbone read data
	output logic             wb_ack_o,    // Wishbone acknowledge
	input  wire logic        run_i,       // Run command pin
	input  wire logic [15:0] freq_i,      // Output frequency, 0.1 Hz
	input  wire logic        meas_done_i, // Measurement finished
	input  wire logic        meas_ok_i,   // Measurement succeeded
	input  wire logic [15:0] meas_res_i,  // Measured resistance
	input  wire logic [15:0] meas_ofs_i,  // Measured voltage offset
	output logic             meas_start_o,// Start measurement pulse
	output logic             nv_write_o,  // Nonvolatile save pulse
	output logic [15:0]      nv_res_o,    // Resistance to save
	output logic [15:0]      nv_ofs_o,    // Offset to save
	output logic [2:0]       nv_mode_o,   // Mode to save
	output logic [15:0]      volt_o,      // Voltage command, 0.1 V
	output logic [15:0]      comp_o,      // Weighted resistance
	output logic             running_o    // Normal characteristic active
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		olv_pkg::olv_state_type state;
		logic [2:0]             mode;
		logic [15:0]            rfreq;
		logic [15:0]            rvolt;
		logic [15:0]            boost;
		logic [15:0]            rset;
		logic [15:0]            ofs;
		logic                   first_done;
		logic                   fail;
		logic                   sync1;
		logic                   sync2;
		logic                   start;
		logic                   nvw;
		logic                   ack;
		logic [31:0]            dat;
	} olv_top_type;
	olv_top_type r, n;
	logic        elapsed;
	logic        need;
	olv_curve_if cv ();
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] olv_wr16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] v;
		v = old;
		if (sel[0])
			v[7:0] = d[7:0];
		if (sel[1])
			v[15:8] = d[15:8];
		return v;
	endfunction
	function automatic logic olv_vec(input logic [2:0] m);
		return m == olv_pkg::MEASURE_EVERY_RUN_MODE ||
			m == olv_pkg::NO_MEASUREMENT_VECTOR_MODE ||
			m == olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE ||
			m == olv_pkg::MEASURE_FIRST_RUN_AFTER_POWERUP_MODE;
	endfunction
	// ****************************************
	// Sub-blocks
	// ****************************************
	olv_tick #(
		.TICK_CYC      (TICK_CYC),
		.HOLDOFF_TICKS (HOLDOFF_TICKS)
	) u_tick (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.clr_i     (r.state != olv_pkg::S_READY),
		.elapsed_o (elapsed)
	);
	olv_vcurve u_curve (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cv    (cv)
	);
	assign cv.en = (r.state == olv_pkg::S_RUN);
	assign cv.vector = olv_vec(r.mode);
	assign cv.square = (r.mode == olv_pkg::FIXED_SQUARE_MODE);
	assign cv.freq = freq_i;
	assign cv.rfreq = r.rfreq;
	assign cv.rvolt = r.rvolt;
	assign cv.boost = r.boost;
	assign cv.res = r.rset;
	assign cv.ofs = r.ofs;
	// ****************************************
	// Measurement decision
	// ****************************************
	always_comb begin
		unique case (r.mode)
			olv_pkg::MEASURE_EVERY_RUN_MODE:
				need = elapsed;
			olv_pkg::MEASURE_FIRST_RUN_AFTER_POWERUP_MODE:
				need = !r.first_done;
			olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE:
				need = 1'b1;
			default:
				need = 1'b0;
		endcase
	end
	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = r;
		n.sync1 = run_i;
		n.sync2 = r.sync1;
		n.start = 1'b0;
		n.nvw = 1'b0;
		n.ack = wb_cyc_i && wb_stb_i && !r.ack;
		n.dat = 32'h0;
		if (n.ack && wb_we_i) begin
			unique case (wb_adr_i)
				olv_pkg::ADR_MODE:
					if (wb_sel_i[0] && wb_dat_i[2:0] <= 3'h5)
						n.mode = wb_dat_i[2:0];
				olv_pkg::ADR_RFREQ:
					n.rfreq = olv_wr16(r.rfreq, wb_dat_i, wb_sel_i);
				olv_pkg::ADR_RVOLT:
					n.rvolt = olv_wr16(r.rvolt, wb_dat_i, wb_sel_i);
				olv_pkg::ADR_BOOST:
					n.boost = olv_wr16(r.boost, wb_dat_i, wb_sel_i);
				olv_pkg::ADR_RSET:
					n.rset = olv_wr16(r.rset, wb_dat_i, wb_sel_i);
				olv_pkg::ADR_OFS:
					n.ofs = olv_wr16(r.ofs, wb_dat_i, wb_sel_i);
				olv_pkg::ADR_STAT:
					if (wb_sel_i[0] && wb_dat_i[olv_pkg::STAT_FAIL])
						n.fail = 1'b0;
				default: ;
			endcase
		end
		if (n.ack && !wb_we_i) begin
			unique case (wb_adr_i)
				olv_pkg::ADR_MODE:  n.dat = {29'h0, r.mode};
				olv_pkg::ADR_RFREQ: n.dat = {16'h0, r.rfreq};
				olv_pkg::ADR_RVOLT: n.dat = {16'h0, r.rvolt};
				olv_pkg::ADR_BOOST: n.dat = {16'h0, r.boost};
				olv_pkg::ADR_RSET:  n.dat = {16'h0, r.rset};
				olv_pkg::ADR_OFS:   n.dat = {16'h0, r.ofs};
				olv_pkg::ADR_STAT:  n.dat = {27'h0, r.fail,
					r.first_done, r.state[2:0]};
				default: n.dat = 32'h0;
			endcase
		end
		// Hardware updates come last so they win over bus writes
		unique case (r.state)
			olv_pkg::S_READY: begin
				if (r.sync2 && need) begin
					n.state = olv_pkg::S_MEAS;
					n.start = 1'b1;
				end else if (r.sync2) begin
					n.state = olv_pkg::S_RUN;
				end
			end
			olv_pkg::S_MEAS: begin
				if (!r.sync2) begin
					n.state = olv_pkg::S_READY;
				end else if (meas_done_i && meas_ok_i) begin
					n.rset = meas_res_i;
					n.ofs = meas_ofs_i;
					n.first_done = 1'b1;
					n.state = olv_pkg::S_RUN;
					if (r.mode == olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE) begin
						n.mode = olv_pkg::NO_MEASUREMENT_VECTOR_MODE;
						n.nvw = 1'b1;
					end
				end else if (meas_done_i) begin
					n.fail = 1'b1;
					n.state = olv_pkg::S_FAULT;
				end
			end
			olv_pkg::S_RUN:
				if (!r.sync2)
					n.state = olv_pkg::S_READY;
			olv_pkg::S_FAULT:
				if (!r.sync2)
					n.state = olv_pkg::S_READY;
		endcase
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{state: olv_pkg::S_READY, mode: olv_pkg::RST_MODE,
				rfreq: olv_pkg::RST_RFREQ, rvolt: olv_pkg::RST_RVOLT,
				boost: olv_pkg::RST_BOOST, rset: olv_pkg::RST_RSET,
				ofs: olv_pkg::RST_OFS, dat: 32'h0, default: 1'b0};
		end else begin
			r <= n;
		end
	end
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign meas_start_o = r.start;
	assign nv_write_o = r.nvw;
	assign nv_res_o = r.rset;
	assign nv_ofs_o = r.ofs;
	assign nv_mode_o = r.mode;
	assign volt_o = cv.volt;
	assign comp_o = cv.comp;
	assign running_o = r.state[2];
	// ****************************************
	// Checks
	// ****************************************
	property p_zero_out;
		@(posedge clk_i) disable iff (rst_i)
		(r.state != olv_pkg::S_RUN) |=> (volt_o == 16'h0);
	endproperty
	a_zero_out: assert property (p_zero_out)
		else $error("voltage not zero outside run");
	property p_every_run;
		@(posedge clk_i) disable iff (rst_i)
		(r.state == olv_pkg::S_READY && r.sync2 && elapsed &&
			r.mode == olv_pkg::MEASURE_EVERY_RUN_MODE) |=> meas_start_o;
	endproperty
	a_every_run: assert property (p_every_run)
		else $error("mode 0 run did not start measurement");
	property p_holdoff;
		@(posedge clk_i) disable iff (rst_i)
		(r.state == olv_pkg::S_READY && r.sync2 && !elapsed &&
			r.mode == olv_pkg::MEASURE_EVERY_RUN_MODE)
		|=> (!meas_start_o && r.state == olv_pkg::S_RUN);
	endproperty
	a_holdoff: assert property (p_holdoff)
		else $error("mode 0 measured inside hold-off");
	property p_first_only;
		@(posedge clk_i) disable iff (rst_i)
		(r.first_done &&
			r.mode == olv_pkg::MEASURE_FIRST_RUN_AFTER_POWERUP_MODE &&
			$rose(r.sync2)) |=> !meas_start_o;
	endproperty
	a_first_only: assert property (p_first_only)
		else $error("mode 4 measured twice");
	property p_no_save;
		@(posedge clk_i) disable iff (rst_i)
		(r.state == olv_pkg::S_MEAS && meas_done_i &&
			r.mode != olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE)
		|=> !nv_write_o;
	endproperty
	a_no_save: assert property (p_no_save)
		else $error("unexpected nonvolatile save");
	property p_never;
		@(posedge clk_i) disable iff (rst_i)
		(r.mode == olv_pkg::NO_MEASUREMENT_VECTOR_MODE) |-> !n.start;
	endproperty
	a_never: assert property (p_never)
		else $error("mode 1 started a measurement");
	property p_lock;
		@(posedge clk_i) disable iff (rst_i)
		(r.state == olv_pkg::S_MEAS && r.sync2 && meas_done_i &&
			meas_ok_i && r.mode == olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE)
		|=> (nv_write_o && nv_mode_o == olv_pkg::NO_MEASUREMENT_VECTOR_MODE
			&& nv_res_o == $past(meas_res_i));
	endproperty
	a_lock: assert property (p_lock)
		else $error("mode 3 did not lock and save");
	property p_retry;
		@(posedge clk_i) disable iff (rst_i)
		(r.state == olv_pkg::S_MEAS && r.sync2 && meas_done_i &&
			!meas_ok_i && r.mode == olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE)
		|=> (nv_mode_o == olv_pkg::MEASURE_ONCE_THEN_LOCK_MODE &&
			!nv_write_o) ##1 r.fail;
	endproperty
	a_retry: assert property (p_retry)
		else $error("mode 3 failure changed mode");
	property p_save_once;
		@(posedge clk_i) disable iff (rst_i)
		nv_write_o |=> !nv_write_o;
	endproperty
	a_save_once: assert property (p_save_once)
		else $error("save pulse longer than one cycle");
endmodule

// ---- bench/olv_stage_model.sv ----
// Purpose: Power stage model that answers resistance measurements
// Assumes: Bench sets ok_i and res_i before each run command
// Notes:   Result lines carry a changing pattern outside the done pulse
`timescale 1ns/1ps
module olv_stage_model #(
	parameter int DELAY = 8
) (
	input  wire logic        clk_i,        // System clock
	input  wire logic        meas_start_i, // Start measurement pulse
	input  wire logic        ok_i,         // Outcome to report
	input  wire logic [15:0] res_i,        // Resistance to report
	input  wire logic [15:0] ofs_i,        // Offset to report
	output logic             meas_done_o,  // Measurement finished
	output logic             meas_ok_o,    // Measurement succeeded
	output logic [15:0]      meas_res_o,   // Measured resistance
	output logic [15:0]      meas_ofs_o    // Measured offset
);
	int          cnt   = 0;
	logic [15:0] noise = 16'h5a5a;
	initial begin
		meas_done_o = 1'b0;
		meas_ok_o   = 1'b0;
		meas_res_o  = 16'h0000;
		meas_ofs_o  = 16'h0000;
	end
	// ****************************************
	// Measurement answer
	// ****************************************
	always @(posedge clk_i) begin
		noise       <= noise + 16'h1357;
		meas_done_o <= 1'b0;
		meas_ok_o   <= ~ok_i;
		meas_res_o  <= noise;
		meas_ofs_o  <= ~noise;
		if (meas_start_i === 1'b1) begin
			cnt <= DELAY;
		end else if (cnt == 1) begin
			meas_done_o <= 1'b1;
			meas_ok_o   <= ok_i;
			meas_res_o  <= res_i;
			meas_ofs_o  <= ofs_i;
			cnt         <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the voltage mode controller
// Assumes: Short tick and hold-off parameters (20 cycles of hold-off)
// Notes:   Tasks are entered just after a rising edge
`timescale 1ns/1ps
module testbench;
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_we_i  = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        run_i    = 1'b0;
	logic [15:0] freq_i   = 16'h0000;
	logic        m_ok     = 1'b0;
	logic [15:0] m_res    = 16'h0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, meas_done_i, meas_ok_i, meas_start_o;
	logic        nv_write_o, running_o;
	logic [15:0] meas_res_i, meas_ofs_i, nv_res_o, nv_ofs_o, volt_o, comp_o;
	logic [2:0]  nv_mode_o;
	logic [15:0] nv_res_cap = 16'h0000;
	logic [2:0]  nv_mode_cap = 3'h0;
	logic        m;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc_cnt = 0;
	int          nv_cnt = 0;

	always #2.5 clk_i = ~clk_i;

	olv_top #(.TICK_CYC(4), .HOLDOFF_TICKS(5)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .run_i(run_i), .freq_i(freq_i),
		.meas_done_i(meas_done_i), .meas_ok_i(meas_ok_i),
		.meas_res_i(meas_res_i), .meas_ofs_i(meas_ofs_i),
		.meas_start_o(meas_start_o), .nv_write_o(nv_write_o),
		.nv_res_o(nv_res_o), .nv_ofs_o(nv_ofs_o), .nv_mode_o(nv_mode_o),
		.volt_o(volt_o), .comp_o(comp_o), .running_o(running_o));

	olv_stage_model stage (
		.clk_i(clk_i), .meas_start_i(meas_start_o), .ok_i(m_ok),
		.res_i(m_res), .ofs_i(16'h0011), .meas_done_o(meas_done_i),
		.meas_ok_o(meas_ok_i), .meas_res_o(meas_res_i),
		.meas_ofs_o(meas_ofs_i));

	// ****************************************
	// Save pulse capture and timeout
	// ****************************************
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (nv_write_o === 1'b1) begin
			nv_cnt++;
			nv_res_cap  <= nv_res_o;
			nv_mode_cap <= nv_mode_o;
		end
		if (cyc_cnt == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic summarize();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wb_acc(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'h3;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			error_cnt++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		edges(2);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb_acc(1'b1, adr, dat, q);
	endtask

	task automatic rdc(input logic [7:0] adr, input logic [31:0] mask,
		input logic [31:0] exp);
		logic [31:0] q;
		wb_acc(1'b0, adr, 32'h0, q);
		chk(q & mask, exp);
	endtask

	task automatic do_reset();
		rst_i <= 1'b1;
		run_i <= 1'b0;
		edges(10);
		rst_i <= 1'b0;
		edges(1);
	endtask

	// Output must stay at zero while a measurement is pending
	task automatic run_cmd(input logic ok, input logic [15:0] res,
		output logic meas);
		int n;
		n = 0;
		meas = 1'b0;
		m_ok  <= ok;
		m_res <= res;
		run_i <= 1'b1;
		while (running_o !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
			if (meas_start_o === 1'b1)
				meas = 1'b1;
			if (meas)
				chk({16'h0, volt_o}, 32'h0);
		end
	endtask

	task automatic stop();
		run_i <= 1'b0;
		edges(6);
	endtask

	task automatic fchk(input logic [15:0] f, input logic [15:0] exp);
		freq_i <= f;
		edges(5);
		chk({16'h0, volt_o}, {16'h0, exp});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset();
		rdc(olv_pkg::ADR_MODE, 32'hffff, 32'h1);
		rdc(olv_pkg::ADR_RFREQ, 32'hffff, 32'h1f4);
		rdc(olv_pkg::ADR_RVOLT, 32'hffff, 32'hfa0);
		rdc(olv_pkg::ADR_STAT, 32'h1f, 32'h1);
		wr(8'h1c, 32'hffff);
		rdc(8'h1c, 32'hffffffff, 32'h0);
		wr(olv_pkg::ADR_RSET, 32'h200);
		wr(olv_pkg::ADR_OFS, 32'h40);
		wr(olv_pkg::ADR_BOOST, 32'h64);
		rdc(olv_pkg::ADR_RSET, 32'hffff, 32'h200);
		run_cmd(1'b1, 16'h0000, m);
		chk(m, 1'b0);
		fchk(16'h03e8, 16'h0fa0);
		fchk(16'h00fa, 16'h07d0);
		chk({16'h0, comp_o}, 32'h0);
		fchk(16'h000a, 16'h008f);
		chk({16'h0, comp_o}, 32'h200);
		fchk(16'h0064, 16'h035f);
		chk({16'h0, comp_o}, 32'h200);
		fchk(16'h00c8, 16'h0658);
		chk({16'h0, comp_o}, 32'hcd);
		stop();
		wr(olv_pkg::ADR_MODE, 32'h2);
		run_cmd(1'b1, 16'h0000, m);
		chk(m, 1'b0);
		fchk(16'h0000, 16'h0064);
		fchk(16'h00fa, 16'h0802);
		fchk(16'h03e8, 16'h0fa0);
		stop();
		wr(olv_pkg::ADR_MODE, 32'h5);
		run_cmd(1'b1, 16'h0000, m);
		fchk(16'h0000, 16'h0064);
		fchk(16'h00fa, 16'h041a);
		fchk(16'h07d0, 16'h0fa0);
		stop();
		wr(olv_pkg::ADR_MODE, 32'h3);
		run_cmd(1'b0, 16'h0123, m);
		chk(m, 1'b1);
		chk(running_o, 1'b0);
		stop();
		rdc(olv_pkg::ADR_MODE, 32'hffff, 32'h3);
		rdc(olv_pkg::ADR_STAT, 32'h10, 32'h10);
		chk(nv_cnt, 0);
		run_cmd(1'b1, 16'h0123, m);
		chk(m, 1'b1);
		chk(running_o, 1'b1);
		edges(1);
		chk(nv_cnt, 1);
		chk({16'h0, nv_ofs_o}, 32'h11);
		chk(nv_res_cap, 16'h0123);
		chk(nv_mode_cap, 3'h1);
		stop();
		rdc(olv_pkg::ADR_MODE, 32'hffff, 32'h1);
		rdc(olv_pkg::ADR_RSET, 32'hffff, 32'h123);
		wr(olv_pkg::ADR_STAT, 32'h10);
		rdc(olv_pkg::ADR_STAT, 32'h10, 32'h0);
		do_reset();
		wr(olv_pkg::ADR_MODE, 32'h4);
		run_cmd(1'b1, 16'h0456, m);
		chk(m, 1'b1);
		stop();
		rdc(olv_pkg::ADR_STAT, 32'h8, 32'h8);
		run_cmd(1'b1, 16'h0789, m);
		chk(m, 1'b0);
		stop();
		rdc(olv_pkg::ADR_RSET, 32'hffff, 32'h456);
		wr(olv_pkg::ADR_MODE, 32'h0);
		edges(60);
		run_cmd(1'b1, 16'h0abc, m);
		chk(m, 1'b1);
		stop();
		run_cmd(1'b1, 16'h0def, m);
		chk(m, 1'b0);
		stop();
		rdc(olv_pkg::ADR_RSET, 32'hffff, 32'habc);
		edges(60);
		run_cmd(1'b1, 16'h0def, m);
		chk(m, 1'b1);
		stop();
		rdc(olv_pkg::ADR_RSET, 32'hffff, 32'hdef);
		chk(nv_cnt, 1);
		summarize();
	end
endmodule
